// *** rtl/paged_control_access_reset.sv ***
// Paged register access, reset sequencing and signalling stream steering
`timescale 1ns/1ps
`default_nettype none
`include "paged_access_consts.svh"

module paged_control_access_reset #(
    parameter int                  RESET_CYCLES = `RESET_TIME_NS / `CLK_PERIOD_NS,
    parameter paged_access_pkg::byte_t ID_CODE  = 8'h5a  // Arbitrary value
) (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       cs_n_i,
    input  wire logic       strobe_a_n_i,
    input  wire logic       strobe_b_i,
    input  wire logic [4:0] addr_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] data_o,
    output logic            data_oe_o,
    input  wire logic       bus_style_select_i,
    input  wire logic       force_all_ones_n_i,
    output logic            irq_n_o,
    output logic            irq_oe_o,
    output logic            reset_busy_o,
    input  wire logic       chan_valid_i,
    input  wire logic [4:0] chan_i,
    input  wire logic [3:0] signalling_stream_in_i,
    input  wire logic [3:0] rx_sig_i,
    input  wire logic [7:0] voice_stream_in_i,
    input  wire logic [7:0] rx_voice_i,
    output logic            chan_valid_o,
    output logic      [3:0] tx_sig_o,
    output logic      [3:0] signalling_stream_out_o,
    output logic      [7:0] tx_voice_o,
    output logic      [7:0] voice_stream_out_o
);

    // ======================================================================
    // Elaboration checks
    generate
        if (RESET_CYCLES < 1 || RESET_CYCLES > 65535)
        begin : g_bad_reset
            $error("RESET_CYCLES out of range");
        end
    endgenerate

    // ======================================================================
    // Decoding functions
    // Maps a writable page to its storage slot
    function automatic logic [4:0] page_slot(input logic [7:0] pg);
        logic [4:0] r;
        r = 5'h10;
        if (pg == `PG_MCTL_A) r = 5'h00;
        else if (pg == `PG_MCTL_B) r = 5'h01;
        else if (pg == `PG_STAT) r = 5'h02;
        else if (pg == `PG_TXSIG_A) r = 5'h03;
        else if (pg == `PG_TXSIG_B) r = 5'h04;
        else if (pg == `PG_TSCTL_A) r = 5'h05;
        else if (pg == `PG_TSCTL_B) r = 5'h06;
        else if (pg == `PG_HDLC_A) r = 5'h07;
        else if (pg == `PG_HDLC_B) r = 5'h08;
        return r;
    endfunction : page_slot

    // T1 takes the low 24 channels; E1 skips framing and signalling slots
    function automatic logic chan_used(input logic [4:0] ch, input logic e1);
        if (e1)
            return (ch != 5'd0) && (ch != 5'd16);
        else
            return ch < 5'(`T1_CHANNELS);
    endfunction : chan_used

    // ======================================================================
    // Pin synchronisers: three stages, change counts when stages 2 and 3 agree
    logic [3:0] s1_r, s2_r, s3_r, pin_r;
    logic [3:0] pin_nxt;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i];
    end
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            s1_r  <= 4'hf;
            s2_r  <= 4'hf;
            s3_r  <= 4'hf;
            pin_r <= 4'hf;
        end
        else
        begin
            s1_r  <= {force_all_ones_n_i, strobe_b_i, strobe_a_n_i, cs_n_i};
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // Strobe decode by bus style
    logic sel, rd_act, wr_act, forced;
    assign sel    = !pin_r[0] && !pin_r[1];
    assign rd_act = bus_style_select_i ? sel : (sel && pin_r[2]);
    assign wr_act = bus_style_select_i ? (!pin_r[0] && !pin_r[2])
                                       : (sel && !pin_r[2]);
    assign forced = !pin_r[3];

    // ======================================================================
    // Host access, page store and reset sequencer
    paged_access_pkg::seq_state_t st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0]  page_r, page_nxt, dout_r, dout_nxt;
    logic [7:0]  mem_r [0:`SLOT_COUNT-1][0:15];
    logic [7:0]  mem_nxt [0:`SLOT_COUNT-1][0:15];
    logic [3:0]  rxm_r [0:31];
    logic [3:0]  rxm_nxt [0:31];
    logic        acc_prev_r, oe_r, oe_nxt, start, run, e1;
    logic [4:0]  slot;
    logic [3:0]  idx;
    assign run   = (st_r == paged_access_pkg::ST_RUN);
    assign start = (rd_act || wr_act) && !acc_prev_r && run;
    assign slot  = page_slot(page_r);
    assign idx   = addr_i[3:0];
    assign e1    = mem_r[0][0][`MODE_E1_BIT];
    // Next state of registers, read data and reset counter
    always_comb
    begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        page_nxt = page_r;
        dout_nxt = dout_r;
        oe_nxt   = rd_act && run;
        mem_nxt  = mem_r;
        rxm_nxt  = rxm_r;
        if (chan_valid_i && chan_used(chan_i, e1) && run)
            rxm_nxt[chan_i] = rx_sig_i;
        if (!run)
        begin
            // Control registers stay cleared for the whole frame
            cnt_nxt  = cnt_r + 16'd1;
            page_nxt = `RESET_VALUE;
            for (int s = 0; s < `SLOT_COUNT; s++)
                for (int k = 0; k < 16; k++)
                    mem_nxt[s][k] = `RESET_VALUE;
            for (int k = 0; k < 32; k++)
                rxm_nxt[k] = 4'h0;
            if (cnt_r >= 16'(RESET_CYCLES - 1))
                st_nxt = paged_access_pkg::ST_RUN;
        end
        else if (start && wr_act)
        begin
            if (!addr_i[4])
                page_nxt = data_i;
            else if (page_r == `PG_MCTL_A && addr_i == `ADDR_SWRST
                     && data_i[`SWRST_BIT])
            begin
                st_nxt  = paged_access_pkg::ST_RESET;
                cnt_nxt = 16'd0;
            end
            else if (!slot[4])
                mem_nxt[slot[3:0]][idx] = data_i;
        end
        else if (start && rd_act)
        begin
            dout_nxt = 8'h00;
            if (!addr_i[4])
                dout_nxt = 8'h00;
            else if (page_r == `PG_MSTAT && addr_i == `ADDR_IDENTITY)
                dout_nxt = ID_CODE;
            else if (page_r == `PG_MSTAT && addr_i == `ADDR_STATUS)
                dout_nxt = {6'h00, e1, forced};
            else if (page_r == `PG_RXSIG_A)
                dout_nxt = {4'h0, rxm_r[{1'b0, idx}]};
            else if (page_r == `PG_RXSIG_B)
                dout_nxt = {4'h0, rxm_r[{1'b1, idx}]};
            else if (!slot[4])
                dout_nxt = mem_r[slot[3:0]][idx];
        end
    end

    // Registers of the host side; pin reset restarts the frame-long sequence
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            st_r       <= paged_access_pkg::ST_RESET;
            cnt_r      <= 16'd0;
            page_r     <= `RESET_VALUE;
            dout_r     <= 8'h00;
            oe_r       <= 1'b0;
            acc_prev_r <= 1'b0;
            for (int s = 0; s < `SLOT_COUNT; s++)
                for (int k = 0; k < 16; k++)
                    mem_r[s][k] <= `RESET_VALUE;
            for (int k = 0; k < 32; k++)
                rxm_r[k] <= 4'h0;
        end
        else
        begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            page_r     <= page_nxt;
            dout_r     <= dout_nxt;
            oe_r       <= oe_nxt;
            acc_prev_r <= rd_act || wr_act;
            mem_r      <= mem_nxt;
            rxm_r      <= rxm_nxt;
        end
    end

    // ======================================================================
    // Backplane steering; all-ones covers reset and idle channels, and forcing on the transmit side only
    logic [3:0] tsig_nxt, osig_nxt;
    logic [7:0] tv_nxt, ov_nxt, tsctl, txreg;
    logic       use_ch;
    always_comb
    begin
        use_ch   = chan_used(chan_i, e1);
        tsctl    = mem_r[`SLOT_TSCTL_A + 4'(chan_i[4])][chan_i[3:0]];
        txreg    = mem_r[`SLOT_TXSIG_A + 4'(chan_i[4])][chan_i[3:0]];
        tsig_nxt = 4'hf;
        osig_nxt = 4'hf;
        tv_nxt   = `ALL_ONES;
        ov_nxt   = `ALL_ONES;
        if (use_ch && run && !forced)
        begin
            tsig_nxt = tsctl[`SIG_SRC_BIT] ? txreg[3:0]
                                           : signalling_stream_in_i;
            tv_nxt   = voice_stream_in_i;
        end
        if (use_ch && run)
        begin
            osig_nxt = rx_sig_i;
            ov_nxt   = rx_voice_i;
        end
    end

    // Output registers; interrupt pin floats while forcing all ones
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            chan_valid_o            <= 1'b0;
            tx_sig_o                <= 4'hf;
            signalling_stream_out_o <= 4'hf;
            tx_voice_o              <= `ALL_ONES;
            voice_stream_out_o      <= `ALL_ONES;
            irq_n_o                 <= 1'b1;
            irq_oe_o                <= 1'b0;
            reset_busy_o            <= 1'b1;
        end
        else
        begin
            chan_valid_o            <= chan_valid_i;
            tx_sig_o                <= tsig_nxt;
            signalling_stream_out_o <= osig_nxt;
            tx_voice_o              <= tv_nxt;
            voice_stream_out_o      <= ov_nxt;
            irq_n_o                 <= 1'b1;
            irq_oe_o                <= !forced;
            reset_busy_o            <= !run;
        end
    end
    assign data_o    = dout_r;
    assign data_oe_o = oe_r;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    chk_page_load: assert property (start && wr_act && !addr_i[4]
        |=> page_r == $past(data_i)) else $error("page not loaded");
    chk_page_hold: assert property (run && !(start && wr_act && !addr_i[4])
        && $past(run) |=> $stable(page_r) || !run) else $error("page lost");
    chk_id_read: assert property (start && rd_act && page_r == `PG_MSTAT
        && addr_i == `ADDR_IDENTITY |=> data_o == ID_CODE) else $error("bad id");
    chk_unassigned_zero: assert property (start && rd_act && addr_i[4]
        && page_r == 8'h00 |=> data_o == 8'h00) else $error("unassigned read");
    chk_soft_reset: assert property (start && wr_act && page_r == `PG_MCTL_A
        && addr_i == `ADDR_SWRST && data_i[`SWRST_BIT] |=> !run ##1 reset_busy_o)
        else $error("soft reset missed");
    chk_reset_bound: assert property (!run |-> cnt_r < 16'(RESET_CYCLES))
        else $error("reset too long");
    chk_reset_clear: assert property ($rose(run) |-> page_r == 8'h00
        && mem_r[0][0] == 8'h00) else $error("control not cleared");
    chk_tx_source: assert property (chan_valid_i && run && !forced && use_ch
        && !tsctl[`SIG_SRC_BIT] |=> tx_sig_o == $past(signalling_stream_in_i))
        else $error("tx signalling source");
    chk_rx_out: assert property (chan_valid_i && run && use_ch
        |=> signalling_stream_out_o == $past(rx_sig_i)) else $error("rx out");
    chk_idle_ones: assert property (!use_ch || forced
        |=> tx_voice_o == 8'hff) else $error("idle not ones");
    chk_force_float: assert property (forced |=> !irq_oe_o)
        else $error("irq driven while forced");
    cov_soft_reset: cover property (start && wr_act && addr_i == `ADDR_SWRST);
    cov_id_read: cover property (start && rd_act && addr_i == `ADDR_IDENTITY);
    cov_stream_sig: cover property (chan_valid_i && run && use_ch && !forced);
    cov_page_write: cover property (start && wr_act && !addr_i[4]);
endmodule : paged_control_access_reset
`default_nettype wire

// *** rtl/paged_access_consts.svh ***
// Constants for the paged host access, reset and backplane block
// ==========================================================================
// Notes on behaviour
// - Region bit low loads the page select from data; index lines ignored.
// - Region bit high reads or writes one of sixteen registers in current page.
// - Selected page stays until the host writes a new one.
// - Pages 01-0C decode to control, status and signalling with fixed access.
// - Register 1FH of page 03H returns a fixed identity code.
// - Source-select bit low sends stream signalling; received signalling goes out on every used channel, forcing or not.
// - Only 24 channels used in T1, 30 in E1, of 32.
// - Reset comes from the pin or from the software reset bit.
// - Reset lasts one 125 us frame; control registers then read 00H.
// - After reset everything defaults off, masked, cleared, all-ones transmit.
// - Force-all-ones pin low sends all ones and floats the interrupt pin.
// - Bus style pin low selects data-strobe style, high selects read/write strobes.
`ifndef PAGED_ACCESS_CONSTS_SVH
`define PAGED_ACCESS_CONSTS_SVH

// ==========================================================================
// Page numbers
`define PG_MCTL_A      8'h01
`define PG_MCTL_B      8'h02
`define PG_MSTAT       8'h03
`define PG_STAT        8'h04
`define PG_TXSIG_A     8'h05
`define PG_TXSIG_B     8'h06
`define PG_TSCTL_A     8'h07
`define PG_TSCTL_B     8'h08
`define PG_RXSIG_A     8'h09
`define PG_RXSIG_B     8'h0a
`define PG_HDLC_A      8'h0b
`define PG_HDLC_B      8'h0c

// ==========================================================================
// Storage slots of writable pages
`define SLOT_COUNT     9
`define SLOT_TXSIG_A   4'h3
`define SLOT_TSCTL_A   4'h5

// ==========================================================================
// Register addresses and fields
`define ADDR_IDENTITY  5'h1f
`define ADDR_SWRST     5'h1a
`define ADDR_STATUS    5'h10
`define SWRST_BIT      0
`define MODE_E1_BIT    0
`define SIG_SRC_BIT    1
`define RESET_VALUE    8'h00
`define ALL_ONES       8'hff

// ==========================================================================
// Channel use and timing
`define T1_CHANNELS    24
`define RESET_TIME_NS  125000
`define CLK_PERIOD_NS  10

`endif

// *** rtl/paged_access_pkg.sv ***
// Types shared by the paged host access block
`default_nettype none
package paged_access_pkg;
    typedef enum logic {ST_RESET, ST_RUN} seq_state_t;
    typedef logic [7:0] byte_t;
endpackage : paged_access_pkg
`default_nettype wire

// *** verification/host_bus_model.sv ***
// Host processor model for the paged register port
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
    input  wire logic       clk_i,
    input  wire logic       style_i,
    input  wire logic [7:0] rd_data_i,
    input  wire logic       rd_oe_i,
    output logic            cs_n_o,
    output logic            strobe_a_n_o,
    output logic            strobe_b_o,
    output logic      [4:0] addr_o,
    output logic      [7:0] data_o
);
    // ======================================================================
    // Idle levels
    initial
    begin
        cs_n_o       = 1'b1;
        strobe_a_n_o = 1'b1;
        strobe_b_o   = 1'b1;
        addr_o       = 5'h00;
        data_o       = 8'h00;
    end

    // ======================================================================
    // One access; strobe held past the pin synchroniser latency
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic oe);
        @(negedge clk_i);
        cs_n_o       = 1'b0;
        addr_o       = a;
        data_o       = d;
        strobe_a_n_o = style_i ? wr : 1'b0;  // Read strobe, or data strobe
        strobe_b_o   = ~wr;                  // Write strobe, or read-not-write
        repeat (8) @(posedge clk_i);
        q  = rd_data_i;
        oe = rd_oe_i;
        @(negedge clk_i);
        cs_n_o       = 1'b1;
        strobe_a_n_o = 1'b1;
        strobe_b_o   = 1'b1;
        addr_o       = ~a;  // Released lines do not keep the old value
        data_o       = ~d;
        // Idle gap keeps accesses 150 ns apart, start to start
        repeat (6) @(negedge clk_i);
    endtask : access
endmodule : host_bus_model
`default_nettype wire

// *** verification/paged_control_access_reset_tb_top.sv ***
// Self-checking bench for paged access, reset and stream steering
`timescale 1ns/1ps
`default_nettype none
`include "paged_access_consts.svh"

module paged_control_access_reset_tb_top;
    localparam paged_access_pkg::byte_t ID = 8'h3c;  // Arbitrary value
    logic       clk, rst, style, frc_n, cv_i, cs_n, sa_n, sb, e1, frc;
    logic       cv_o, oe, irq_n, irq_oe, busy;
    logic [4:0] addr, ch;
    logic [7:0] wd, rdat, rdat_q, vi, rv, tv, vo;
    logic [3:0] si, rs, ts, so;
    logic [3:0] nib [32];
    logic       src [32];
    logic [7:0] mem [16];
    int         seed, n_errors, tests_run, cyc, i;

    // ======================================================================
    // Design, host and clock
    paged_control_access_reset #(.RESET_CYCLES(40), .ID_CODE(ID)) uut (
        .ref_clk_i(clk), .rst_i(rst), .cs_n_i(cs_n), .strobe_a_n_i(sa_n),
        .strobe_b_i(sb), .addr_i(addr), .data_i(wd), .data_o(rdat), .data_oe_o(oe),
        .bus_style_select_i(style), .force_all_ones_n_i(frc_n), .irq_n_o(irq_n),
        .irq_oe_o(irq_oe), .reset_busy_o(busy), .chan_valid_i(cv_i), .chan_i(ch),
        .signalling_stream_in_i(si), .rx_sig_i(rs), .voice_stream_in_i(vi),
        .rx_voice_i(rv), .chan_valid_o(cv_o), .tx_sig_o(ts),
        .signalling_stream_out_o(so), .tx_voice_o(tv), .voice_stream_out_o(vo));

    host_bus_model host (
        .clk_i(clk), .style_i(style), .rd_data_i(rdat), .rd_oe_i(oe), .cs_n_o(cs_n),
        .strobe_a_n_o(sa_n), .strobe_b_o(sb), .addr_o(addr), .data_o(wd));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    // ======================================================================
    // Helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
        logic o;
        host.access(w, a, d, rdat_q, o);
        if (!w)
            chk({7'h00, o}, 8'h01);
    endtask : acc

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rdat_q, e);
    endtask : rdc

    function automatic logic used(input logic [4:0] c);
        used = e1 ? (c != 5'd0 && c != 5'd16) : (c < 5'd24);
    endfunction : used

    // Storage pages not reached by the main scenarios
    function automatic logic [7:0] page_of(input int k);
        if (k == 0)
            return `PG_MCTL_B;
        else if (k == 1)
            return `PG_TXSIG_B;
        else if (k == 2)
            return `PG_TSCTL_B;
        else if (k == 3)
            return `PG_HDLC_A;
        return `PG_HDLC_B;
    endfunction : page_of

    // One channel through the streams, outputs checked with chan_valid_o
    task automatic chan(input logic [4:0] c);
        int n;
        @(negedge clk);
        ch = c;
        {si, rs, vi, rv} = 24'($random(seed));
        cv_i = 1'b1;
        @(negedge clk);
        cv_i = 1'b0;
        n = 0;
        while (cv_o !== 1'b1 && n < 3)
        begin
            @(negedge clk);
            n++;
        end
        chk({ts, so}, {(!used(c) || frc) ? 4'hf : (src[c] ? nib[c] : si),
                       used(c) ? rs : 4'hf});
        chk(tv, (!used(c) || frc) ? 8'hff : vi);
        chk({7'h00, cv_o}, 8'h01);
        chk(vo, used(c) ? rv : 8'hff);
    endtask : chan

    // Bounded wait for the reset sequence; models defaults afterwards
    task automatic settle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, n > 46}, 8'h00);
        repeat (4) @(negedge clk);
        e1 = 1'b0;
        for (int k = 0; k < 32; k++)
            src[k] = 1'b0;
    endtask : settle

    task automatic hw_reset();
        rst = 1'b1;
        repeat (8) @(negedge clk);
        chk({5'h00, busy, irq_oe, oe}, 8'h04);
        chk(tv, 8'hff);
        rst = 1'b0;
        settle();
    endtask : hw_reset

    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // ======================================================================
    // Main sequence
    initial
    begin
        seed = 54824;
        {rst, style, frc_n, cv_i, e1, frc} = 6'b111000;
        {ch, si, rs, vi, rv} = '0;
        n_errors = 0;
        tests_run = 0;
        hw_reset();
        rdc(5'h13, 8'h00);
        wr(5'h0e, `PG_MSTAT);
        rdc(`ADDR_IDENTITY, ID);
        wr(`ADDR_IDENTITY, 8'h55);
        rdc(`ADDR_IDENTITY, ID);
        rdc(`ADDR_STATUS, 8'h00);
        wr(5'h00, `PG_STAT);
        for (i = 0; i < 16; i++)
        begin
            mem[i] = 8'($random(seed));
            wr({1'b1, i[3:0]}, mem[i]);
        end
        for (i = 0; i < 16; i++)
            rdc({1'b1, i[3:0]}, mem[i]);
        wr(5'h00, 8'h0d);
        wr(5'h13, 8'ha5);
        rdc(5'h13, 8'h00);
        // Channel 3 takes signalling from its register, channel 19 not
        wr(5'h00, `PG_TSCTL_A);
        wr(5'h13, 8'h02);
        wr(5'h00, `PG_TXSIG_A);
        wr(5'h13, 8'h09);
        src[3] = 1'b1;
        nib[3] = 4'h9;
        for (i = 0; i < 32; i++)
            chan(i[4:0]);
        wr(5'h00, `PG_RXSIG_A);
        chan(5'd15);
        wr(5'h1f, {4'h0, ~rs});
        acc(1'b0, 5'h1f, 8'h00);
        chk({4'h0, rdat_q[3:0]}, {4'h0, rs});
        wr(5'h00, `PG_MCTL_A);
        wr(`ADDR_STATUS, 8'h01);
        e1 = 1'b1;
        for (i = 0; i < 32; i++)
            chan(i[4:0]);
        frc_n = 1'b0;
        repeat (6) @(negedge clk);
        chk({6'h00, irq_oe, irq_n}, 8'h01);
        frc = 1'b1;
        chan(5'd1);
        wr(5'h00, `PG_MSTAT);
        rdc(`ADDR_STATUS, 8'h03);
        frc_n = 1'b1;
        frc = 1'b0;
        repeat (6) @(negedge clk);
        chk({6'h00, irq_oe, irq_n}, 8'h03);
        wr(5'h00, `PG_MCTL_A);
        wr(`ADDR_SWRST, 8'h01);
        chk({7'h00, busy}, 8'h01);
        settle();
        wr(5'h00, `PG_MCTL_A);
        rdc(`ADDR_STATUS, 8'h00);
        rdc(5'h15, 8'h00);
        wr(5'h15, 8'h40);                      // Metallic loopback on
        rdc(5'h15, 8'h40);
        wr(5'h00, `PG_TSCTL_A);
        rdc(5'h13, 8'h00);
        chan(5'd3);
        // Second strobe convention after a pin reset
        style = 1'b0;
        hw_reset();
        wr(5'h00, `PG_STAT);
        rdc(5'h15, 8'h00);
        wr(5'h15, mem[0]);
        rdc(5'h15, mem[0]);
        // Remaining storage pages keep their own data apart
        for (i = 0; i < 5; i++)
        begin
            wr(5'h00, page_of(i));
            wr(5'h17, mem[i + 1]);
        end
        for (i = 0; i < 5; i++)
        begin
            wr(5'h00, page_of(i));
            rdc(5'h17, mem[i + 1]);
        end
        wr(5'h00, `PG_RXSIG_B);
        rdc(5'h17, 8'h00);
        end_of_test();
    end
endmodule : paged_control_access_reset_tb_top
`default_nettype wire
